// file: spi_master_config.sv
// configurable serial master channel with an avalon-mm register port
// assumes a single system clock; miso arrives from a pin and is synchronised here
//
// Summary of operation
// - serial clock rate set in hertz
// - phase selects stable edge, data changes opposite
// - polarity sets idle level and edge direction
// - order bit selects msb or lsb first
// - frame length code 3..15 means 4..16 bits
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
module spi_master_config #(
  parameter int NUM_CS = 4                        // number of chip select lines
) (
  input  wire logic              SYS_CLK,         // system clock, 25 MHz
  input  wire logic              RST_N,           // asynchronous reset, active low
  input  wire logic [7:0]        ADDRESS,         // avalon byte address
  input  wire logic              READ,            // avalon read request
  input  wire logic              WRITE,           // avalon write request
  input  wire logic [31:0]       WRITEDATA,       // avalon write data
  input  wire logic [3:0]        BYTEENABLE,      // avalon byte lanes
  output logic [31:0]            READDATA,        // avalon read data
  output logic                   WAITREQUEST,     // avalon stall
  output logic                   SCLK,            // serial clock
  output logic                   MOSI,            // serial data out
  input  wire logic              MISO,            // serial data in, asynchronous
  output logic [NUM_CS-1:0]      CS_N             // chip selects, active low
);

  // ==========================================================
  // types and storage
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_CLOCK, ST_HOLD} xfer_e;

  spi_cfg_pkg::cfg_s  cfg_q;           // live configuration
  logic [31:0]        freq_q;          // requested serial clock in hertz
  logic [15:0]        txdata_q;        // transmit shifter
  logic [15:0]        rxdata_q;        // receive shifter and result
  logic               done_q;          // sticky end-of-transfer flag
  xfer_e              state_q;         // transfer sequencer
  logic [5:0]         edges_q;         // serial clock edges still to issue
  logic [32:0]        acc_q;           // rate accumulator
  logic               tick_q;          // half period enable pulse
  logic               miso_meta_q;     // first synchroniser stage
  logic               miso_sync_q;     // second synchroniser stage
  logic               waitreq_q;       // registered waitrequest
  logic [31:0]        readdata_q;      // registered read data
  logic               sclk_q;          // serial clock level
  logic               mosi_q;          // serial data level
  logic [NUM_CS-1:0]  cs_n_q;          // chip select levels

  logic               req;             // any bus request present
  logic               accept;          // request completes this edge
  logic               wr_ok;           // write completes this edge
  logic               busy;            // transfer under way
  logic               start;           // legal transmit write
  logic               leading;         // next toggle is a leading edge
  logic               drive_edge;      // this toggle drives new data
  logic               sample_edge;     // this toggle samples miso
  logic [32:0]        step;            // accumulator step per cycle
  logic [33:0]        acc_sum;         // accumulator plus step

  // ==========================================================
  // helpers

  // bit that leaves the shifter next, per order
  function automatic logic out_bit(input logic [15:0] sh, input logic [3:0] len, input logic lsb);
    out_bit = lsb ? sh[0] : sh[len];
  endfunction

  // receive shifter after one sampled bit
  function automatic logic [15:0] rx_next(input logic [15:0] sh, input logic [3:0] len, input logic lsb,
                                          input logic b);
    logic [15:0] r;
    r = 16'h0000;
    if (lsb) begin
      r      = sh >> 1;
      r[len] = b;                      // lsb first: new bit enters at frame top
    end else begin
      r = {sh[14:0], b};               // msb first: new bit enters at bit 0
    end
    rx_next = r;
  endfunction

  // ==========================================================
  // bus decode
  assign req     = READ | WRITE;
  assign accept  = req & ~waitreq_q;                  // edge where master sees waitrequest low
  assign wr_ok   = accept & WRITE & (&BYTEENABLE);    // partial writes are ignored
  assign busy    = (state_q != ST_IDLE);
  assign start   = wr_ok & (ADDRESS == spi_cfg_pkg::ADDR_TXDATA) & ~busy & (freq_q != 32'h0);

  // leading edge leaves the idle level
  assign leading     = (sclk_q == cfg_q.cpol);
  assign sample_edge = tick_q & (state_q == ST_CLOCK) & (leading ^ cfg_q.cpha);
  assign drive_edge  = tick_q & (state_q == ST_CLOCK) & ~(leading ^ cfg_q.cpha);

  // ==========================================================
  // waitrequest: one stall cycle per access, then release for one edge
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      waitreq_q <= 1'b1;
    end else if (req && waitreq_q) begin
      waitreq_q <= 1'b0;                // answer on the next edge
    end else begin
      waitreq_q <= 1'b1;                // back to stall once taken
    end
  end

  // read data is captured in the stall cycle so it stands at the accepting edge
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      readdata_q <= 32'h00000000;
    end else if (READ && waitreq_q) begin
      unique case (ADDRESS)
        spi_cfg_pkg::ADDR_CTRL: begin
          readdata_q <= 32'h00000000;
          readdata_q[spi_cfg_pkg::CTRL_PHASE_BIT]                      <= cfg_q.cpha;
          readdata_q[spi_cfg_pkg::CTRL_POL_BIT]                        <= cfg_q.cpol;
          readdata_q[spi_cfg_pkg::CTRL_ORDER_BIT]                      <= cfg_q.lsb_first;
          readdata_q[spi_cfg_pkg::CTRL_LEN_LSB +: 4]                   <= cfg_q.frame_len;
          readdata_q[spi_cfg_pkg::CTRL_CH_LSB +: 4]                    <= cfg_q.channel;
        end
        spi_cfg_pkg::ADDR_FREQ:   readdata_q <= freq_q;
        spi_cfg_pkg::ADDR_TXDATA: readdata_q <= {16'h0000, txdata_q};
        spi_cfg_pkg::ADDR_RXDATA: readdata_q <= {16'h0000, rxdata_q};
        spi_cfg_pkg::ADDR_STATUS: begin
          readdata_q <= 32'h00000000;
          readdata_q[spi_cfg_pkg::STAT_BUSY_BIT] <= busy;
          readdata_q[spi_cfg_pkg::STAT_DONE_BIT] <= done_q;
        end
        default:                  readdata_q <= 32'h00000000;   // unmapped reads as zero
      endcase
    end
  end

  // ==========================================================
  // configuration registers; held while a transfer runs so a frame keeps one mode
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_q <= spi_cfg_pkg::CFG_RESET;
    end else if (wr_ok && !busy && ADDRESS == spi_cfg_pkg::ADDR_CTRL) begin
      cfg_q.cpha      <= WRITEDATA[spi_cfg_pkg::CTRL_PHASE_BIT];
      cfg_q.cpol      <= WRITEDATA[spi_cfg_pkg::CTRL_POL_BIT];
      cfg_q.lsb_first <= WRITEDATA[spi_cfg_pkg::CTRL_ORDER_BIT];
      cfg_q.channel   <= WRITEDATA[spi_cfg_pkg::CTRL_CH_LSB +: 4];
      // codes below the minimum leave the old length in place
      if (WRITEDATA[spi_cfg_pkg::CTRL_LEN_LSB +: 4] >= spi_cfg_pkg::LEN_MIN) begin
        cfg_q.frame_len <= WRITEDATA[spi_cfg_pkg::CTRL_LEN_LSB +: 4];
      end
    end
  end

  // requested rate in hertz
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      freq_q <= spi_cfg_pkg::FREQ_RESET;
    end else if (wr_ok && !busy && ADDRESS == spi_cfg_pkg::ADDR_FREQ) begin
      freq_q <= WRITEDATA;
    end
  end

  // ==========================================================
  // rate generator: accumulates twice the rate, one tick per half period
  // trade-off: no divider needed, but edges jitter by one cycle for rates that do not divide evenly
  always_comb begin
    if (freq_q > 32'(spi_cfg_pkg::MAX_SCLK_HZ)) begin
      step = {1'b0, 32'(spi_cfg_pkg::MAX_SCLK_HZ)} << 1;        // clamp to one edge per cycle
    end else begin
      step = {freq_q, 1'b0};
    end
    acc_sum = {1'b0, acc_q} + {1'b0, step};
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_q  <= 33'h000000000;
      tick_q <= 1'b0;
    end else if (!busy || start) begin
      acc_q  <= 33'h000000000;          // each frame starts on a fresh phase
      tick_q <= 1'b0;
    end else if (acc_sum >= 34'(spi_cfg_pkg::SYS_CLK_HZ)) begin
      acc_q  <= 33'(acc_sum - 34'(spi_cfg_pkg::SYS_CLK_HZ));
      tick_q <= 1'b1;
    end else begin
      acc_q  <= acc_sum[32:0];
      tick_q <= 1'b0;
    end
  end

  // ==========================================================
  // miso synchroniser; only the second stage feeds logic
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      miso_meta_q <= 1'b0;
      miso_sync_q <= 1'b0;
    end else begin
      miso_meta_q <= MISO;
      miso_sync_q <= miso_meta_q;
    end
  end

  // ==========================================================
  // transfer sequencer: setup half period, 2n edges, hold half period
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
      edges_q <= 6'h00;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_SETUP;
            edges_q <= {1'b0, cfg_q.frame_len, 1'b0} + 6'h02;    // two edges per bit
          end
        end
        ST_SETUP: begin
          if (tick_q) begin
            state_q <= ST_CLOCK;
          end
        end
        ST_CLOCK: begin
          if (tick_q) begin
            edges_q <= edges_q - 6'h01;
            if (edges_q == 6'h01) begin
              state_q <= ST_HOLD;       // last edge returned clock to idle
            end
          end
        end
        ST_HOLD: begin
          if (tick_q) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // serial clock: toggles once per tick while clocking, idles at polarity otherwise
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sclk_q <= spi_cfg_pkg::CFG_RESET.cpol;
    end else if (state_q == ST_CLOCK && tick_q) begin
      sclk_q <= ~sclk_q;
    end else if (state_q != ST_CLOCK) begin
      sclk_q <= cfg_q.cpol;
    end
  end

  // chip select: low from start until the hold half period ends
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cs_n_q <= '1;
    end else if (start) begin
      cs_n_q <= ~(NUM_CS'(1) << cfg_q.channel);
    end else if (state_q == ST_HOLD && tick_q) begin
      cs_n_q <= '1;                     // release with clock already idle
    end
  end

  // ==========================================================
  // transmit path: phase 0 presents the first bit at select, phase 1 on the first leading edge
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      txdata_q <= 16'h0000;
      mosi_q   <= 1'b0;
    end else if (start) begin
      if (!cfg_q.cpha) begin
        mosi_q   <= out_bit(WRITEDATA[15:0], cfg_q.frame_len, cfg_q.lsb_first);
        txdata_q <= cfg_q.lsb_first ? (WRITEDATA[15:0] >> 1) : (WRITEDATA[15:0] << 1);
      end else begin
        txdata_q <= WRITEDATA[15:0];
      end
    end else if (drive_edge) begin
      mosi_q   <= out_bit(txdata_q, cfg_q.frame_len, cfg_q.lsb_first);
      txdata_q <= cfg_q.lsb_first ? (txdata_q >> 1) : (txdata_q << 1);
    end else if (state_q == ST_IDLE) begin
      mosi_q <= 1'b0;                   // quiet line between frames
    end
  end

  // receive path: sample on the stable edge; result is valid once done sets
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rxdata_q <= 16'h0000;
    end else if (start) begin
      rxdata_q <= 16'h0000;
    end else if (sample_edge) begin
      rxdata_q <= rx_next(rxdata_q, cfg_q.frame_len, cfg_q.lsb_first, miso_sync_q);
    end
  end

  // done flag: set at frame end wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      done_q <= 1'b0;
    end else if (state_q == ST_HOLD && tick_q) begin
      done_q <= 1'b1;
    end else if (wr_ok && ADDRESS == spi_cfg_pkg::ADDR_STATUS && WRITEDATA[spi_cfg_pkg::STAT_DONE_BIT]) begin
      done_q <= 1'b0;
    end else if (start) begin
      done_q <= 1'b0;                   // a new frame invalidates the old result
    end
  end

  // ==========================================================
  // outputs straight from flip-flops
  assign READDATA    = readdata_q;
  assign WAITREQUEST = waitreq_q;
  assign SCLK        = sclk_q;
  assign MOSI        = mosi_q;
  assign CS_N        = cs_n_q;

endmodule // spi_master_config

// file: spi_cfg_pkg.sv
// constants, field layouts and types shared by the configurable serial master
// assumes a 25 MHz system clock and a 32-bit avalon-mm register port
package spi_cfg_pkg;

  // ==========================================================
  // clocking
  localparam int unsigned SYS_CLK_HZ   = 25_000_000;      // system clock rate in hertz
  localparam int unsigned MAX_SCLK_HZ  = SYS_CLK_HZ / 2;  // fastest serial clock: one edge per cycle

  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;  // mode, frame length, channel
  localparam logic [7:0] ADDR_FREQ   = 8'h04;  // serial clock in hertz
  localparam logic [7:0] ADDR_TXDATA = 8'h08;  // write starts a transfer
  localparam logic [7:0] ADDR_RXDATA = 8'h0c;  // last received frame
  localparam logic [7:0] ADDR_STATUS = 8'h10;  // busy and done

  // ==========================================================
  // control field positions
  localparam int CTRL_PHASE_BIT = 0;   // 0 stable on leading, 1 stable on trailing
  localparam int CTRL_POL_BIT   = 1;   // 0 idle low, 1 idle high
  localparam int CTRL_ORDER_BIT = 2;   // 0 msb first, 1 lsb first
  localparam int CTRL_LEN_LSB   = 4;   // encoded frame length, bits 7:4
  localparam int CTRL_CH_LSB    = 8;   // channel select, bits 11:8

  // status field positions
  localparam int STAT_BUSY_BIT  = 0;   // transfer in progress
  localparam int STAT_DONE_BIT  = 1;   // sticky, write one to clear

  // ==========================================================
  // encoded frame length limits and reset values
  localparam logic [3:0]  LEN_MIN      = 4'h3;          // 4-bit frames
  localparam logic [3:0]  LEN_MAX      = 4'hf;          // 16-bit frames
  localparam logic [3:0]  LEN_RESET    = 4'h7;          // 8-bit frames
  localparam logic [31:0] FREQ_RESET   = 32'h000f4240;  // 1 MHz

  // ==========================================================
  // configuration carried as one unit
  typedef struct packed {
    logic [3:0] channel;    // which chip select to drive
    logic [3:0] frame_len;  // encoded length, bits minus one
    logic       lsb_first;  // bit order
    logic       cpol;       // idle level of serial clock
    logic       cpha;       // edge on which data is stable
  } cfg_s;

  localparam cfg_s CFG_RESET = '{channel: 4'h0, frame_len: LEN_RESET, lsb_first: 1'b0, cpol: 1'b0, cpha: 1'b0};

endpackage : spi_cfg_pkg

// file: spi_master_config_checker.sv
// concurrent checks on the pins of the configurable serial master
// assumes the bus master drops its request at the accepting edge
module spi_master_config_checker #(
  parameter int NUM_CS = 4                   // number of chip select lines
) (
  input  wire logic              SYS_CLK,     // system clock
  input  wire logic              RST_N,       // reset, active low
  input  wire logic [7:0]        ADDRESS,     // bus address
  input  wire logic              READ,        // bus read
  input  wire logic              WRITE,       // bus write
  input  wire logic [3:0]        BYTEENABLE,  // bus lanes
  input  wire logic              WAITREQUEST, // bus stall
  input  wire logic              SCLK,        // serial clock
  input  wire logic              MOSI,        // serial out
  input  wire logic [NUM_CS-1:0] CS_N         // chip selects
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // ==========================================================
  // helper terms
  wire sel   = ~&CS_N;                  // some line selected
  wire wdone = ~WAITREQUEST & WRITE;    // write completing at this edge
  wire start = wdone & ~sel & BYTEENABLE == 4'hf & ADDRESS == spi_cfg_pkg::ADDR_TXDATA;
  wire ctrl  = wdone & ADDRESS == spi_cfg_pkg::ADDR_CTRL;  // idle level may move after this
  // ==========================================================
  // bus handshake
  a_wait_answer: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
    else $error("access not answered after one stall");
  a_wait_single: assert property (!WAITREQUEST |=> WAITREQUEST)
    else $error("stall low for more than one cycle");
  a_wait_rest: assert property (!READ && !WRITE && WAITREQUEST |=> WAITREQUEST)
    else $error("answer without request");
  // ==========================================================
  // framing on the wire
  a_start_select: assert property (start |=> sel)
    else $error("transfer did not select a line");
  a_sel_edges: assert property ($rose(sel) || $fell(sel) |-> $stable(SCLK))
    else $error("serial clock moved with chip select");
  a_mosi_rest: assert property (!sel && $past(!sel) |-> !MOSI)
    else $error("data line not low between frames");
  a_one_select: assert property ($onehot0(~CS_N))
    else $error("more than one line selected");
  a_sclk_rest: assert property ($changed(SCLK) |-> sel || $past(ctrl) || $past(ctrl, 2))
    else $error("serial clock moved outside a frame");
  c_frame: cover property ($rose(sel));
  c_start: cover property (start);
  c_idle_flip: cover property ($changed(SCLK) && !sel);
endmodule // spi_master_config_checker

bind spi_master_config spi_master_config_checker #(.NUM_CS(NUM_CS)) chk_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .BYTEENABLE(BYTEENABLE), .WAITREQUEST(WAITREQUEST),
  .SCLK(SCLK), .MOSI(MOSI), .CS_N(CS_N));

// file: spi_slave_model.sv
// behavioural serial slave on one chip select line
// assumes the bench hands it the mode that the master is set to
module spi_slave_model (
  input  wire logic              sclk,  // serial clock from master
  input  wire logic              mosi,  // data from master
  input  wire logic              sel_n, // its chip select
  input  wire spi_cfg_pkg::cfg_s cfg,   // mode in force
  input  wire logic [15:0]       reply, // word sent back
  output logic                   miso,  // data to master
  output logic [15:0]            got    // word received
);
  timeunit 1ns;
  timeprecision 1ns;
  int   k;      // bits sampled so far
  logic last_q; // last bit driven
  // wire position of the i-th bit for the chosen order
  function automatic int pos(int i);
    return cfg.lsb_first ? i : cfg.frame_len - i;
  endfunction
  // drive bit k; it stands until the next change edge
  task automatic put();
    last_q = reply[pos(k)];
    miso = last_q;
  endtask
  initial begin
    miso = 1'b0;
    last_q = 1'b0;
    k = 0;
    got = '0;
  end
  // phase 0 needs the first bit out before the leading edge
  always @(negedge sel_n) begin
    k = 0;
    got = '0;
    if (!cfg.cpha) put();
  end
  // a released line shows the inverse, so a stale bit never passes
  always @(posedge sel_n) miso = ~last_q;
  // leading edge leaves the idle level; stable edge samples, the other drives
  always @(sclk) if (!sel_n) begin
    if ((sclk != cfg.cpol) != cfg.cpha) begin
      got[pos(k)] = mosi;
      k++;
    end else if (k <= cfg.frame_len) put();
  end
endmodule // spi_slave_model

// file: spi_master_config_test.sv
// self-checking bench for the configurable serial master
// assumes one slave model that follows whichever line is selected
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
module spi_master_config_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 5;  // system cycles per serial half period
  localparam logic [31:0] FREQ = spi_cfg_pkg::SYS_CLK_HZ / (2 * HALF);
  logic              sys_clk, rst_n, rd, wr, sclk, mosi, miso, wait_req, sclk_d;
  logic [7:0]        addr;
  logic [31:0]       wdata, rdata, r;
  logic [3:0]        be, cs_n, seen, i;
  logic [15:0]       reply, got;
  spi_cfg_pkg::cfg_s cfg;
  int                fails, checks, cyc, edges, first, last;
  // ==========================================================
  // clock, design and partner
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  spi_master_config dut_u (.SYS_CLK(sys_clk), .RST_N(rst_n), .ADDRESS(addr), .READ(rd), .WRITE(wr),
    .WRITEDATA(wdata), .BYTEENABLE(be), .READDATA(rdata), .WAITREQUEST(wait_req), .SCLK(sclk),
    .MOSI(mosi), .MISO(miso), .CS_N(cs_n));
  spi_slave_model peer_u (.sclk(sclk), .mosi(mosi), .sel_n(cs_n[cfg.channel]), .cfg(cfg),
    .reply(reply), .miso(miso), .got(got));
  // ==========================================================
  // monitor: serial edges inside a frame, lines selected, hang limit
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      stop_test();
    end
    seen = seen | ~cs_n;  // blocking, so a clear made by the sequence at this edge is never undone
    if (sclk !== sclk_d && !(&cs_n)) begin
      if (edges == 0) first = cyc;
      last = cyc;
      edges++;
    end
    sclk_d <= sclk;
  end
  // ==========================================================
  // verdict and end of run
  task automatic stop_test();
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one bus access; held until the stall drops, read data taken there
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    do @(posedge sys_clk); while (wait_req !== 1'b0);
    r = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // one frame in mode m = {order, polarity, phase}; a mid-frame config write must bounce
  task automatic xfer(input logic [3:0] ch, input logic [3:0] len, input logic [2:0] m, input logic [15:0] d);
    logic [15:0] mask;
    mask = 16'hffff >> (4'hf - len);
    cfg = '{channel: ch, frame_len: len, lsb_first: m[2], cpol: m[1], cpha: m[0]};
    reply = {d[7:0], d[15:8]};
    acc(1'b1, spi_cfg_pkg::ADDR_CTRL, {20'h0, ch, len, 1'b0, m});
    edges = 0;
    seen = 4'h0;
    acc(1'b1, spi_cfg_pkg::ADDR_TXDATA, {16'h0, d});
    acc(1'b1, spi_cfg_pkg::ADDR_CTRL, 32'h0);
    do acc(1'b0, spi_cfg_pkg::ADDR_STATUS, 32'h0); while (r[0] !== 1'b0);
    `CHK(r[1:0], 2'b10)
    `CHK(edges, 2 * (len + 1))
    `CHK(last - first, (2 * len + 1) * HALF)
    `CHK(seen, 4'h1 << ch)
    `CHK({sclk, cs_n}, {m[1], 4'hf})
    `CHK(got, d & mask)
    acc(1'b0, spi_cfg_pkg::ADDR_RXDATA, 32'h0);
    `CHK(r, {16'h0, reply & mask})
    acc(1'b0, spi_cfg_pkg::ADDR_CTRL, 32'h0);
    `CHK(r, {20'h0, ch, len, 1'b0, m})
  endtask
  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    {rd, wr, sclk_d} = 3'h0;
    addr = 8'h00;
    wdata = 32'h0;
    be = 4'hf;
    {fails, checks, cyc, edges} = 0;
    seen = 4'h0;
    cfg = spi_cfg_pkg::CFG_RESET;
    reply = 16'h0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    `CHK({sclk, mosi, cs_n, wait_req}, 7'h1f)
    acc(1'b0, spi_cfg_pkg::ADDR_CTRL, 32'h0);
    `CHK(r, {24'h0, spi_cfg_pkg::LEN_RESET, 4'h0})
    acc(1'b0, spi_cfg_pkg::ADDR_FREQ, 32'h0);
    `CHK(r, spi_cfg_pkg::FREQ_RESET)
    acc(1'b0, 8'h14, 32'h0);
    `CHK(r, 32'h0)
    acc(1'b1, spi_cfg_pkg::ADDR_FREQ, FREQ);
    // every phase, polarity and order; lengths from the shortest to the longest
    for (i = 4'h0; i < 4'h8; i++) begin
      xfer({2'b00, i[1:0]}, i == 4'h7 ? 4'hf : 4'h3 + {i[2:0], 1'b0}, i[2:0], 16'h5a3c ^ {4{i}});
    end
    // a length code below the minimum leaves the old length in place
    acc(1'b1, spi_cfg_pkg::ADDR_CTRL, 32'h20);
    acc(1'b0, spi_cfg_pkg::ADDR_CTRL, 32'h0);
    `CHK(r, 32'hf0)
    // sticky done clears on a written one
    acc(1'b1, spi_cfg_pkg::ADDR_STATUS, 32'h2);
    acc(1'b0, spi_cfg_pkg::ADDR_STATUS, 32'h0);
    `CHK(r, 32'h0)
    // a rate write with one lane off is acknowledged but must leave the rate alone
    be <= 4'h7;
    acc(1'b1, spi_cfg_pkg::ADDR_FREQ, 32'h0);
    be <= 4'hf;
    acc(1'b0, spi_cfg_pkg::ADDR_FREQ, 32'h0);
    `CHK(r, FREQ)
    stop_test();
  end
endmodule // spi_master_config_test
